/* pkg/uvd_pkg.sv */
// Register map, field layout and source encodings of the undervoltage
// flag and diagnostic source select bank.
// Assumes a 32-bit Avalon-MM slave, one register per aligned word.
package uvd_pkg;
    localparam int unsigned NUM_CH      = 8;
    localparam int unsigned SEL_W       = 3;
    localparam int unsigned REG_W       = 8;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned NUM_SEL_REG = 4;

    // Printed offsets are register indices; byte address is index * 4
    localparam logic [ADDR_W-1:0] IDX_RANGE_EN  = 8'h25;
    localparam logic [ADDR_W-1:0] IDX_LOW_FLAGS = 8'h27;
    localparam logic [ADDR_W-1:0] IDX_SEL_12    = 8'h28;
    localparam logic [ADDR_W-1:0] IDX_SEL_34    = 8'h29;
    localparam logic [ADDR_W-1:0] IDX_SEL_56    = 8'h2a;
    localparam logic [ADDR_W-1:0] IDX_SEL_78    = 8'h2b;

    localparam logic [REG_W-1:0] RST_LOW_FLAGS = 8'h00;
    localparam logic [REG_W-1:0] RST_SEL       = 8'h00;
    localparam logic [REG_W-1:0] RST_RANGE_EN  = 8'h00;

    localparam int unsigned SEL_ODD_LSB  = 0;
    localparam int unsigned SEL_EVEN_LSB = 3;
    localparam logic [REG_W-1:0] SEL_RD_MASK = 8'h3f;

    typedef enum logic [SEL_W-1:0] {
        UVD_SRC_PIN      = 3'h0,
        UVD_SRC_TEMP     = 3'h1,
        UVD_SRC_REF_X4   = 3'h2,
        UVD_SRC_A_LDO_X4 = 3'h3,
        UVD_SRC_LDO_X4   = 3'h4,
        UVD_SRC_IFACE    = 3'h5,
        UVD_SRC_GND      = 3'h6,
        UVD_SRC_SUPPLY   = 3'h7
    } uvd_src_t;

    // One-hot route codes driven to the analog switch matrix
    localparam int unsigned ROUTE_W = 8;
    localparam logic [ROUTE_W-1:0] RT_PIN   = 8'h01;
    localparam logic [ROUTE_W-1:0] RT_TEMP  = 8'h02;
    localparam logic [ROUTE_W-1:0] RT_REF   = 8'h04;
    localparam logic [ROUTE_W-1:0] RT_A_LDO  = 8'h08;
    localparam logic [ROUTE_W-1:0] RT_D_LDO  = 8'h10;
    localparam logic [ROUTE_W-1:0] RT_IFACE  = 8'h20;
    localparam logic [ROUTE_W-1:0] RT_GND    = 8'h40;
    localparam logic [ROUTE_W-1:0] RT_SUPPLY = 8'h80;

    typedef enum logic [2:0] {
        UVD_ST_IDLE = 3'b001,
        UVD_ST_RESP = 3'b010,
        UVD_ST_DONE = 3'b100
    } uvd_state_t;
endpackage

/* verification/uvd_diag_bank_bench.sv */
// Self-checking bench of the diagnostic bank.
// Assumes the bench is the only Avalon-MM master.
`timescale 1ns/1ns
module uvd_diag_bank_bench;
    logic        CLK_I = 0;
    logic        RST_B_I = 0;
    logic [9:0]  AVS_ADDRESS_I = '0;
    logic        AVS_READ_I = 0;
    logic        AVS_WRITE_I = 0;
    logic [31:0] AVS_WRITEDATA_I = '0;
    logic [3:0]  AVS_BYTEENABLE_I = 4'h1;
    logic [7:0]  ren;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [7:0]  LOW_DETECT_I = '0;
    logic [7:0]  flg;
    logic [23:0] sel;
    logic [63:0] rte;
    wire  [31:0] AVS_READDATA_O;
    wire  [1:0]  AVS_RESPONSE_O;
    wire         AVS_WAITREQUEST_O;
    int          n_fail = 0;
    int          comparisons = 0;
    uvd_diag_bank dut (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
        .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
        .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
        .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_RESPONSE_O(AVS_RESPONSE_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .LOW_DETECT_I(LOW_DETECT_I), .LOW_FAULT_FLAGS_O(flg),
        .RANGE_CHECK_ENABLE_O(ren), .SOURCE_SELECT_O(sel),
        .SOURCE_ROUTE_O(rte));
    initial forever #5 CLK_I = ~CLK_I;
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // One access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [7:0] det = 8'h00);
        int n;
        n = 0;
        AVS_ADDRESS_I <= {idx, 2'b00};
        AVS_WRITEDATA_I <= {24'h0, wd};
        AVS_WRITE_I <= wr;
        AVS_READ_I <= !wr;
        // Optional detector pulse that stands at the first edge only, which is the take edge after an earlier access
        if (det != 8'h00)
            LOW_DETECT_I <= det;
        @(posedge CLK_I);
        if (det != 8'h00)
            LOW_DETECT_I <= 8'h00;
        while (AVS_WAITREQUEST_O !== 1'b0 && ++n < 20)
            @(posedge CLK_I);
        if (n >= 20)
        begin
            n_fail++;
            test_done();
        end
        rd = AVS_READDATA_O;
        rs = AVS_RESPONSE_O;
        AVS_WRITE_I <= 0;
        AVS_READ_I <= 0;
        @(posedge CLK_I);
    endtask
    task automatic t_reset();
        for (int r = 0; r < 7; r++)
        begin
            if (r == 1)
                continue;
            bus(0, 8'h25 + r[7:0], 8'h0);
            chk(rd, 0);
            chk(rs, 2'b00);
        end
        chk(rte, {8{8'h01}});
    endtask
    task automatic t_sel();
        logic [7:0] e;
        for (int c = 0; c < 8; c++)
        begin
            for (int r = 0; r < 4; r++)
                bus(1, 8'h28 + r[7:0], {2'h3, c[2:0], c[2:0]});
            for (int r = 0; r < 4; r++)
            begin
                bus(0, 8'h28 + r[7:0], 8'h0);
                chk(rd, {c[2:0], c[2:0]});
            end
            chk(sel, {8{c[2:0]}});
            e = (c == 4) ? 8'h08 : 8'h01 << c;
            // Range setting lives outside this bank, kept by the host
            for (int n = 0; n < 8; n++)
                chk(rte[n*8 +: 8], n[0] ? e : 8'h1 << c);
        end
    endtask
    task automatic t_flags();
        LOW_DETECT_I <= 8'hff;
        @(posedge CLK_I);
        LOW_DETECT_I <= 8'h00;
        repeat (2) @(posedge CLK_I);
        chk(flg, 0);
        bus(1, 8'h25, 8'ha5);
        chk(ren, 8'ha5);
        LOW_DETECT_I <= 8'hff;
        @(posedge CLK_I);
        LOW_DETECT_I <= 8'h00;
        repeat (3) @(posedge CLK_I);
        chk(flg, 8'ha5);
        bus(0, 8'h27, 8'h0);
        chk(rd, 8'ha5);
        bus(1, 8'h27, 8'h00);
        bus(1, 8'h27, 8'h01);
        bus(0, 8'h27, 8'h0);
        chk(rd, 8'ha4);
        bus(1, 8'h27, 8'h04, 8'h04);
        @(posedge CLK_I);
        chk(flg, 8'ha4);
        bus(1, 8'h27, 8'hff);
        @(posedge CLK_I);
        chk(flg, 0);
    endtask
    task automatic t_bad();
        bus(0, 8'h26, 8'h0);
        chk(rs, 2'b10);
        chk(rd, 0);
        // Write without lane 0 enabled must leave the register alone
        AVS_BYTEENABLE_I <= 4'h0;
        bus(1, 8'h28, 8'h00);
        AVS_BYTEENABLE_I <= 4'h1;
        bus(0, 8'h28, 8'h0);
        chk(rd, 8'h3f);
    endtask
    initial
    begin
        repeat (5) @(posedge CLK_I);
        RST_B_I <= 1;
        @(posedge CLK_I);
        t_reset();
        t_sel();
        t_flags();
        t_bad();
        test_done();
    end
    initial
    begin
        #200000;
        n_fail++;
        test_done();
    end
endmodule

/* verification/uvd_diag_bank_properties.sv */
// Checker of the diagnostic bank, watching top ports only.
// Assumes binding into uvd_diag_bank.
`timescale 1ns/1ns
module uvd_chk #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic                CLK_I,
    input wire logic                RST_B_I,
    input wire logic [9:0]          AVS_ADDRESS_I,
    input wire logic                AVS_READ_I,
    input wire logic                AVS_WRITE_I,
    input wire logic [31:0]         AVS_READDATA_O,
    input wire logic                AVS_WAITREQUEST_O,
    input wire logic [NUM_CH-1:0]   LOW_DETECT_I,
    input wire logic [NUM_CH-1:0]   LOW_FAULT_FLAGS_O,
    input wire logic [NUM_CH-1:0]   RANGE_CHECK_ENABLE_O,
    input wire logic [NUM_CH*3-1:0] SOURCE_SELECT_O,
    input wire logic [NUM_CH*8-1:0] SOURCE_ROUTE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [NUM_CH-1:0] hit_q;
    logic              ans;
    logic              sel_rd;
    assign ans = !AVS_WAITREQUEST_O;
    assign sel_rd = ans && AVS_READ_I && AVS_ADDRESS_I[9:4] == 6'h0a;
    always_ff @(posedge CLK_I or negedge RST_B_I)
        if (!RST_B_I)
            hit_q <= '0;
        else
            hit_q <= LOW_DETECT_I & RANGE_CHECK_ENABLE_O;
    sequence s_answer;
        ans ##1 AVS_WAITREQUEST_O [*2];
    endsequence
    AST_WAIT_ONE: assert property (ans |-> s_answer)
        else $error("waitrequest low longer than one cycle");
    AST_FLAG_SET: assert property
        ((LOW_FAULT_FLAGS_O & hit_q) == hit_q)
        else $error("enabled detection did not set its flag");
    AST_FLAG_ENABLED: assert property
        ((LOW_FAULT_FLAGS_O & ~$past(LOW_FAULT_FLAGS_O) & ~hit_q) == 0)
        else $error("flag rose without an enabled detection");
    AST_FLAG_STICKY: assert property
        ((~LOW_FAULT_FLAGS_O & $past(LOW_FAULT_FLAGS_O)) != 0 |->
         ans && AVS_WRITE_I && AVS_ADDRESS_I[9:2] == 8'h27)
        else $error("flag dropped without a clearing write");
    AST_FLAG_READ: assert property
        (ans && AVS_READ_I && AVS_ADDRESS_I[9:2] == 8'h27 |->
         AVS_READDATA_O == {24'h0, $past(LOW_FAULT_FLAGS_O)})
        else $error("flag register read mismatch");
    AST_SEL_RSVD: assert property
        (sel_rd |-> AVS_READDATA_O[31:6] == 0)
        else $error("select register reserved bits not zero");
    AST_SEL_READ: assert property
        (sel_rd |-> AVS_READDATA_O[5:0] ==
         SOURCE_SELECT_O[AVS_ADDRESS_I[3:2]*6 +: 6])
        else $error("select register read mismatch");
    AST_ROUTE_ODD: assert property
        (SOURCE_ROUTE_O[7:0] == 8'h01 << SOURCE_SELECT_O[2:0])
        else $error("channel 1 route mismatch");
    AST_ROUTE_EVEN: assert property (SOURCE_ROUTE_O[15:8] ==
        ((SOURCE_SELECT_O[5:3] == 3'h4) ? 8'h08
                                        : 8'h01 << SOURCE_SELECT_O[5:3]))
        else $error("channel 2 route mismatch");
endmodule
bind uvd_diag_bank uvd_chk #(.NUM_CH(NUM_CH)) u_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .LOW_DETECT_I(LOW_DETECT_I), .LOW_FAULT_FLAGS_O(LOW_FAULT_FLAGS_O),
    .RANGE_CHECK_ENABLE_O(RANGE_CHECK_ENABLE_O),
    .SOURCE_SELECT_O(SOURCE_SELECT_O), .SOURCE_ROUTE_O(SOURCE_ROUTE_O));

/* verilog/uvd_diag_bank.sv */
// Top of the undervoltage flag and diagnostic source select bank.
// Assumes an Avalon-MM master on CLK_I; detectors are synchronous.
`timescale 1ns/1ns

// How it works
// - Eight-bit undervoltage flag register at 0x27, bit n-1 is channel n.
// - Flag bits read back; writing one clears, writing zero keeps.
// - Flags read zero after reset.
// - Register 0x28: channel 2 select [5:3], channel 1 select [2:0].
// - Register 0x29: channel 4 select [5:3], channel 3 select [2:0].
// - Register 0x2A: channel 6 select [5:3], channel 5 select [2:0].
// - Select register bits [7:6] are read-only zero.
// - Select 000 routes the normal analog pin; reset value.
// - Select 001 routes the die temperature sensor.
// - Select 010 routes the reference scaled by four.
// - Select 011 routes the analog LDO rail scaled by four.
// - Odd channels: select 100 routes the digital LDO rail.
// - Even channels: select 100 routes the analog LDO rail.
// - Selects 101, 110, 111 route interface supply, ground, supply.
// - Select register at 0x2B exists and resets to zero.
// - Register 0x2B: channel 8 select [5:3], channel 7 select [2:0].
// - Flags set only for channels enabled in 0x25; enables reset zero.
module uvd_diag_bank #(
    parameter int unsigned NUM_CH = uvd_pkg::NUM_CH
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RST_B_I,
    input  wire logic [uvd_pkg::ADDR_W+1:0]   AVS_ADDRESS_I,
    input  wire logic                         AVS_READ_I,
    input  wire logic                         AVS_WRITE_I,
    input  wire logic [uvd_pkg::DATA_W-1:0]   AVS_WRITEDATA_I,
    input  wire logic [3:0]                   AVS_BYTEENABLE_I,
    output logic      [uvd_pkg::DATA_W-1:0]   AVS_READDATA_O,
    output logic      [1:0]                   AVS_RESPONSE_O,
    output logic                              AVS_WAITREQUEST_O,
    input  wire logic [NUM_CH-1:0]            LOW_DETECT_I,
    output logic      [NUM_CH-1:0]            LOW_FAULT_FLAGS_O,
    output logic      [NUM_CH-1:0]            RANGE_CHECK_ENABLE_O,
    output logic [NUM_CH*uvd_pkg::SEL_W-1:0]  SOURCE_SELECT_O,
    output logic [NUM_CH*uvd_pkg::ROUTE_W-1:0] SOURCE_ROUTE_O
);
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int unsigned RW = uvd_pkg::REG_W;

    uvd_pkg::uvd_state_t state_q;
    uvd_pkg::uvd_state_t state_d;
    logic [RW-1:0] sel_q [uvd_pkg::NUM_SEL_REG];
    logic [RW-1:0] sel_d [uvd_pkg::NUM_SEL_REG];
    logic [RW-1:0] en_q;
    logic [RW-1:0] en_d;
    logic [uvd_pkg::DATA_W-1:0] rdata_q;
    logic [uvd_pkg::DATA_W-1:0] rdata_d;
    logic [1:0] resp_q;
    logic [1:0] resp_d;
    logic [uvd_pkg::ADDR_W-1:0] idx;
    logic         take;
    logic         wr_lane0;
    logic         clr_flags;
    logic [RW-1:0] flags;

    // Index from byte address; low two bits ignored
    function automatic logic is_sel(input logic [uvd_pkg::ADDR_W-1:0] a);
        return (a >= uvd_pkg::IDX_SEL_12) && (a <= uvd_pkg::IDX_SEL_78);
    endfunction

    function automatic logic is_mapped(input logic [uvd_pkg::ADDR_W-1:0] a);
        return is_sel(a) || (a == uvd_pkg::IDX_LOW_FLAGS)
            || (a == uvd_pkg::IDX_RANGE_EN);
    endfunction

    assign idx = AVS_ADDRESS_I[uvd_pkg::ADDR_W+1:2];
    assign take = (state_q == uvd_pkg::UVD_ST_IDLE)
                  && (AVS_READ_I || AVS_WRITE_I);
    assign wr_lane0 = take && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
    assign clr_flags = wr_lane0 && (idx == uvd_pkg::IDX_LOW_FLAGS);

    uvd_low_flags #(
        .N (RW)
    ) u_flags (
        .clk_i        (CLK_I),
        .rst_b_i      (RST_B_I),
        .detect_i     (RW'(LOW_DETECT_I)),
        .enable_i     (en_q),
        .clear_i      (clr_flags),
        .clear_mask_i (AVS_WRITEDATA_I[RW-1:0]),
        .flags_o      (flags)
    );

    always_comb
    begin
        state_d = state_q;
        en_d    = en_q;
        rdata_d = rdata_q;
        resp_d  = resp_q;
        for (int i = 0; i < uvd_pkg::NUM_SEL_REG; i++)
        begin
            sel_d[i] = sel_q[i];
        end
        case (state_q)
            uvd_pkg::UVD_ST_IDLE:
            begin
                if (take)
                begin
                    state_d = uvd_pkg::UVD_ST_RESP;
                    rdata_d = '0;
                    resp_d  = is_mapped(idx) ? RESP_OK : RESP_ERR;
                    if (AVS_READ_I)
                    begin
                        if (idx == uvd_pkg::IDX_LOW_FLAGS)
                        begin
                            rdata_d[RW-1:0] = flags;
                        end
                        else if (idx == uvd_pkg::IDX_RANGE_EN)
                        begin
                            rdata_d[RW-1:0] = en_q;
                        end
                        else if (is_sel(idx))
                        begin
                            rdata_d[RW-1:0] = sel_q[2'(idx
                                - uvd_pkg::IDX_SEL_12)]
                                & uvd_pkg::SEL_RD_MASK;
                        end
                    end
                    else if (wr_lane0)
                    begin
                        if (idx == uvd_pkg::IDX_RANGE_EN)
                        begin
                            en_d = AVS_WRITEDATA_I[RW-1:0];
                        end
                        else if (is_sel(idx))
                        begin
                            sel_d[2'(idx - uvd_pkg::IDX_SEL_12)] =
                                AVS_WRITEDATA_I[RW-1:0]
                                & uvd_pkg::SEL_RD_MASK;
                        end
                    end
                end
            end
            uvd_pkg::UVD_ST_RESP:
            begin
                state_d = uvd_pkg::UVD_ST_DONE;
            end
            uvd_pkg::UVD_ST_DONE:
            begin
                state_d = uvd_pkg::UVD_ST_IDLE;
            end
            default:
            begin
                state_d = uvd_pkg::UVD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_q <= uvd_pkg::UVD_ST_IDLE;
            en_q    <= uvd_pkg::RST_RANGE_EN;
            rdata_q <= '0;
            resp_q  <= RESP_OK;
            for (int i = 0; i < uvd_pkg::NUM_SEL_REG; i++)
            begin
                sel_q[i] <= uvd_pkg::RST_SEL;
            end
        end
        else
        begin
            state_q <= state_d;
            en_q    <= en_d;
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
            for (int i = 0; i < uvd_pkg::NUM_SEL_REG; i++)
            begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    // Low while the answer stands; the master releases at that edge
    assign AVS_WAITREQUEST_O = (state_q != uvd_pkg::UVD_ST_RESP);
    assign AVS_READDATA_O    = rdata_q;
    assign AVS_RESPONSE_O    = resp_q;
    assign LOW_FAULT_FLAGS_O    = flags[NUM_CH-1:0];
    assign RANGE_CHECK_ENABLE_O = en_q[NUM_CH-1:0];

    // Channel 2k+1 sits in the low field, 2k+2 in the high field
    // The 10 V range for non-pin sources is left to the host
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        localparam int unsigned LSB = (c % 2 == 0) ? uvd_pkg::SEL_ODD_LSB
                                                   : uvd_pkg::SEL_EVEN_LSB;
        assign SOURCE_SELECT_O[c*uvd_pkg::SEL_W +: uvd_pkg::SEL_W] =
            sel_q[c/2][LSB +: uvd_pkg::SEL_W];
        uvd_route_dec #(
            .ODD_CH (c % 2 == 0)
        ) u_dec (
            .sel_i   (sel_q[c/2][LSB +: uvd_pkg::SEL_W]),
            .route_o (SOURCE_ROUTE_O[c*uvd_pkg::ROUTE_W +: uvd_pkg::ROUTE_W])
        );
    end
endmodule

/* verilog/uvd_low_flags.sv */
// Sticky per-channel undervoltage flags with write-one-to-clear.
// Assumes detector inputs are synchronous to the clock.
`timescale 1ns/1ns
module uvd_low_flags #(
    parameter int unsigned N = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [N-1:0] detect_i,
    input  wire logic [N-1:0] enable_i,
    input  wire logic         clear_i,
    input  wire logic [N-1:0] clear_mask_i,
    output logic      [N-1:0] flags_o
);
    logic [N-1:0] flags_q;
    logic [N-1:0] flags_d;
    logic [N-1:0] set_v;

    always_comb
    begin
        set_v   = detect_i & enable_i;
        flags_d = flags_q;
        if (clear_i)
        begin
            flags_d = flags_q & ~clear_mask_i;
        end
        flags_d = flags_d | set_v;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flags_q <= N'(uvd_pkg::RST_LOW_FLAGS);
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
endmodule

/* verilog/uvd_route_dec.sv */
// Decodes one channel's source select into a one-hot route code.
// Assumes the analog switch matrix is registered downstream.
`timescale 1ns/1ns
module uvd_route_dec #(
    parameter bit ODD_CH = 1'b1
) (
    input  wire logic [uvd_pkg::SEL_W-1:0]   sel_i,
    output logic      [uvd_pkg::ROUTE_W-1:0] route_o
);
    always_comb
    begin
        case (sel_i)
            uvd_pkg::UVD_SRC_PIN:     route_o = uvd_pkg::RT_PIN;
            uvd_pkg::UVD_SRC_TEMP:    route_o = uvd_pkg::RT_TEMP;
            uvd_pkg::UVD_SRC_REF_X4:  route_o = uvd_pkg::RT_REF;
            uvd_pkg::UVD_SRC_A_LDO_X4: route_o = uvd_pkg::RT_A_LDO;
            uvd_pkg::UVD_SRC_LDO_X4:
            begin
                // Odd channels see the digital rail, even the analog one
                route_o = ODD_CH ? uvd_pkg::RT_D_LDO
                                 : uvd_pkg::RT_A_LDO;
            end
            uvd_pkg::UVD_SRC_IFACE:   route_o = uvd_pkg::RT_IFACE;
            uvd_pkg::UVD_SRC_GND:     route_o = uvd_pkg::RT_GND;
            uvd_pkg::UVD_SRC_SUPPLY:  route_o = uvd_pkg::RT_SUPPLY;
            default:                  route_o = uvd_pkg::RT_PIN;
        endcase
    end
endmodule
